// *** verilog/sbr_defs.vh ***
`ifndef SBR_DEFS_VH
`define SBR_DEFS_VH

// Register offsets
`define OFS_CARD_MODE_FORMAT   3'h0
`define OFS_BIT_RATE_DIVISOR   3'h1
`define OFS_SERIAL_MODE        3'h2
`define OFS_TRANSMIT_HOLDING   3'h3
`define OFS_RECEIVE_HOLDING    3'h4
`define OFS_STATUS             3'h5

// Card mode and format register fields
`define CMF_CARD_MODE_SELECT   0
`define CMF_DATA_INVERT        2
`define CMF_BIT_ORDER_SELECT   3
`define CMF_RESERVED_ONES      8'hF2

// Serial mode register fields
`define SMR_PRESCALE_LO        0
`define SMR_PRESCALE_HI        1
`define SMR_BASE_CLK_LO        2
`define SMR_BASE_CLK_HI        3
`define SMR_CLOCKED_SYNC       4
`define SMR_SEVEN_BIT          5
`define SMR_PARITY_ENABLE      6
`define SMR_PARITY_ODD         7

// Status register fields
`define STAT_TX_BUSY           0
`define STAT_RX_FULL           1
`define STAT_PARITY_ERR        2

// Reset values
`define RST_BIT_RATE_DIVISOR   8'hFF
`define RST_SERIAL_MODE        8'h00
`define RST_HOLDING            8'h00

// Base ticks per bit after a 4^n prescale and a (divisor+1) count
`define TICKS_ASYNC            10'h020
`define TICKS_SYNC             10'h004
`define TICKS_CARD_32          10'h040
`define TICKS_CARD_64          10'h080
`define TICKS_CARD_372         10'h2E8
`define TICKS_CARD_256         10'h200

// Prescale terminal counts, 4^n - 1
`define PRE_TC_0               6'h00
`define PRE_TC_1               6'h03
`define PRE_TC_2               6'h0F
`define PRE_TC_3               6'h3F

`define DATA_MASK_7            8'h7F
`define DATA_MASK_8            8'hFF

`endif

// *** verilog/base_clock_gen.v ***
`timescale 1ns/1ns
`default_nettype none
`include "sbr_defs.vh"

module base_clock_gen (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // Settings
    input  wire [1:0] prescale_i,
    input  wire [7:0] divisor_i,
    // Tick out
    output wire       base_tick_o
);

    reg  [5:0] pre_cnt_r;
    reg  [7:0] div_cnt_r;
    reg  [5:0] pre_tc;
    wire       pre_tick;

    always @* begin
        case (prescale_i)
            2'h0:    pre_tc = `PRE_TC_0;
            2'h1:    pre_tc = `PRE_TC_1;
            2'h2:    pre_tc = `PRE_TC_2;
            default: pre_tc = `PRE_TC_3;
        endcase
    end

    assign pre_tick    = (pre_cnt_r >= pre_tc);
    assign base_tick_o = pre_tick && (div_cnt_r == 8'h00);

    // Down-counter reloads from the divisor, one tick per reload
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_cnt_r <= 6'h00;
            div_cnt_r <= `RST_BIT_RATE_DIVISOR;
        end else begin
            if (pre_tick) begin
                pre_cnt_r <= 6'h00;
                if (div_cnt_r == 8'h00) begin
                    div_cnt_r <= divisor_i;
                end else begin
                    div_cnt_r <= div_cnt_r - 8'h01;
                end
            end else begin
                pre_cnt_r <= pre_cnt_r + 6'h01;
            end
        end
    end

endmodule // base_clock_gen

`default_nettype wire

// *** verilog/bit_period_counter.v ***
`timescale 1ns/1ns
`default_nettype none

module bit_period_counter (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // Control
    input  wire       base_tick_i,
    input  wire       clear_i,
    input  wire [9:0] limit_i,
    // Bit timing pulses
    output wire       end_o,
    output wire       mid_o
);

    reg  [9:0] cnt_r;
    wire [9:0] last;
    wire [9:0] half;

    assign last  = limit_i - 10'h001;
    assign half  = {1'b0, limit_i[9:1]} - 10'h001;
    assign end_o = base_tick_i && !clear_i && (cnt_r == last);
    assign mid_o = base_tick_i && !clear_i && (cnt_r == half);

    always @(posedge clk_i) begin
        if (!rst_n_i || clear_i) begin
            cnt_r <= 10'h000;
        end else if (base_tick_i) begin
            if (cnt_r >= last) begin
                cnt_r <= 10'h000;
            end else begin
                cnt_r <= cnt_r + 10'h001;
            end
        end
    end

endmodule // bit_period_counter

`default_nettype wire

// *** verilog/serial_bit_rate_and_card_format.v ***
// Summary of operation
// - Card-mode select bit 0 high selects smart-card operation, else async/sync.
// - Bit-order bit 3: zero shifts LSB first, one shifts MSB first.
// - Bit order applies to 8-bit frames only; 7-bit frames always LSB first.
// - Data-invert bit 2 inverts transmit data and stores receive data inverted.
// - Inversion never touches parity; parity sense comes from odd/even select.
// - Reserved card-mode bits 7..4 and 1 read one; functional bits reset zero.
// - Divisor register is 8 bits, resets to all ones, always read/writable.
// - Each channel owns an independent bit-rate generator.
// - Async bit rate is clock / (64 * 2^(2n-1) * (divisor+1)).
// - Synchronous bit rate is clock / (8 * 2^(2n-1) * (divisor+1)).
// - Smart-card bit rate is clock / (S * 2^(2n+1) * (divisor+1)).
// - Prescale exponent n equals the two-bit clock-select field, 0 to 3.
// - Base-clocks-per-bit codes select 32, 64, 372 and 256.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "sbr_defs.vh"

module serial_bit_rate_and_card_format (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // Register port
    input  wire [2:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // Serial line
    input  wire       rxd_i,
    output reg        txd_o,
    output reg        sck_o,
    // Mode indication
    output wire       card_mode_o
);

    localparam TX_IDLE  = 3'h0;
    localparam TX_START = 3'h1;
    localparam TX_DATA  = 3'h2;
    localparam TX_PAR   = 3'h3;
    localparam TX_STOP  = 3'h4;

    localparam RX_IDLE  = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_DATA  = 3'h2;
    localparam RX_PAR   = 3'h3;
    localparam RX_STOP  = 3'h4;

    // Software-visible state
    reg        card_mode_select_r;
    reg        data_invert_r;
    reg        bit_order_select_r;
    reg  [7:0] bit_rate_divisor_r;
    reg  [7:0] serial_mode_r;
    reg  [7:0] tx_hold_r;
    reg        tx_pend_r;
    reg  [7:0] rx_hold_r;
    reg        rx_full_r;
    reg        par_err_r;

    // Transmit path
    reg  [2:0] tx_state_r;
    reg  [7:0] tx_sh_r;
    reg        tx_par_r;
    reg  [2:0] tx_idx_r;

    // Receive path
    reg        rx_s1_r;
    reg        rx_s2_r;
    reg        rx_s3_r;
    reg  [2:0] rx_state_r;
    reg  [7:0] rx_sh_r;
    reg        rx_par_r;
    reg  [2:0] rx_idx_r;

    reg  [9:0] ticks_per_bit;
    reg  [7:0] rd_mux;
    wire       sync_mode;
    wire       seven_bit;
    wire       par_en;
    wire       par_odd;
    wire [7:0] data_mask;
    wire [2:0] last_idx;
    wire       msb_first;
    wire       base_tick;
    wire       tx_go;
    wire       tx_clr;
    wire       tx_end;
    wire       tx_mid;
    wire       rx_clr;
    wire       rx_mid_raw;
    wire       rx_mid;
    wire       rx_fall;
    wire       rx_done;
    wire [7:0] tx_inv;
    wire [7:0] tx_rev;
    wire [7:0] tx_fmt;
    wire       tx_par_bit;
    wire [7:0] rx_raw;
    wire [7:0] rx_rev;
    wire [7:0] rx_fmt;
    wire       rd_rx_hold;

    assign sync_mode   = serial_mode_r[`SMR_CLOCKED_SYNC] && !card_mode_select_r;
    assign seven_bit   = serial_mode_r[`SMR_SEVEN_BIT];
    assign par_en      = serial_mode_r[`SMR_PARITY_ENABLE] && !sync_mode;
    assign par_odd     = serial_mode_r[`SMR_PARITY_ODD];
    assign data_mask   = seven_bit ? `DATA_MASK_7 : `DATA_MASK_8;
    assign last_idx    = seven_bit ? 3'h6 : 3'h7;
    assign msb_first   = bit_order_select_r && !seven_bit;
    assign card_mode_o = card_mode_select_r;

    // Bit period per mode after the 4^n and (divisor+1) stages
    always @* begin
        if (card_mode_select_r) begin
            case (serial_mode_r[`SMR_BASE_CLK_HI:`SMR_BASE_CLK_LO])
                2'h0:    ticks_per_bit = `TICKS_CARD_32;
                2'h1:    ticks_per_bit = `TICKS_CARD_64;
                2'h2:    ticks_per_bit = `TICKS_CARD_372;
                default: ticks_per_bit = `TICKS_CARD_256;
            endcase
        end else if (sync_mode) begin
            ticks_per_bit = `TICKS_SYNC;
        end else begin
            ticks_per_bit = `TICKS_ASYNC;
        end
    end

    // This channel's own generator n from the clock select
    base_clock_gen u_base_clock_gen (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .prescale_i  (serial_mode_r[`SMR_PRESCALE_HI:`SMR_PRESCALE_LO]),
        .divisor_i   (bit_rate_divisor_r),
        .base_tick_o (base_tick)
    );

    bit_period_counter u_tx_period (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .base_tick_i (base_tick),
        .clear_i     (tx_clr),
        .limit_i     (ticks_per_bit),
        .end_o       (tx_end),
        .mid_o       (tx_mid)
    );

    bit_period_counter u_rx_period (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .base_tick_i (base_tick),
        .clear_i     (rx_clr),
        .limit_i     (ticks_per_bit),
        .end_o       (),
        .mid_o       (rx_mid_raw)
    );

    // Bit reversal for MSB-first transfers
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_rev
            assign tx_rev[i] = tx_inv[7-i];
            assign rx_rev[i] = rx_raw[7-i];
        end
    endgenerate

    assign tx_inv     = data_invert_r ? (tx_hold_r ^ data_mask) : (tx_hold_r & data_mask);
    assign tx_fmt     = msb_first ? tx_rev : tx_inv;
    // Parity on the uninverted data, sense only from odd select
    assign tx_par_bit = (^(tx_hold_r & data_mask)) ^ par_odd;

    assign rx_raw = seven_bit ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
    assign rx_fmt = data_invert_r ? ((msb_first ? rx_rev : rx_raw) ^ data_mask)
                                  : (msb_first ? rx_rev : rx_raw);

    assign tx_go   = (tx_state_r == TX_IDLE) && tx_pend_r;
    assign tx_clr  = tx_go;
    assign rx_fall = rx_s3_r && !rx_s2_r;
    assign rx_clr  = (rx_state_r == RX_IDLE) && rx_fall && !sync_mode;
    // Sync mode receives in step with the transmit clock
    assign rx_mid  = sync_mode ? tx_mid : rx_mid_raw;
    assign rx_done = rx_mid && (((rx_state_r == RX_STOP)) ||
                     (sync_mode && rx_state_r == RX_DATA && rx_idx_r == last_idx));
    assign rd_rx_hold = rd_i && (addr_i == `OFS_RECEIVE_HOLDING);

    // Register writes
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            card_mode_select_r <= 1'b0;
            data_invert_r      <= 1'b0;
            bit_order_select_r <= 1'b0;
            bit_rate_divisor_r <= `RST_BIT_RATE_DIVISOR;
            serial_mode_r      <= `RST_SERIAL_MODE;
            tx_hold_r          <= `RST_HOLDING;
        end else if (wr_i) begin
            case (addr_i)
                `OFS_CARD_MODE_FORMAT: begin
                    card_mode_select_r <= wdata_i[`CMF_CARD_MODE_SELECT];
                    data_invert_r      <= wdata_i[`CMF_DATA_INVERT];
                    bit_order_select_r <= wdata_i[`CMF_BIT_ORDER_SELECT];
                end
                `OFS_BIT_RATE_DIVISOR: bit_rate_divisor_r <= wdata_i;
                `OFS_SERIAL_MODE:      serial_mode_r      <= wdata_i;
                `OFS_TRANSMIT_HOLDING: tx_hold_r          <= wdata_i;
                default: ;
            endcase
        end
    end

    // Transmit request and receive flags; a hardware set beats a clear
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_pend_r <= 1'b0;
            rx_full_r <= 1'b0;
            par_err_r <= 1'b0;
            rx_hold_r <= `RST_HOLDING;
        end else begin
            if (wr_i && addr_i == `OFS_TRANSMIT_HOLDING) begin
                tx_pend_r <= 1'b1;
            end else if (tx_go) begin
                tx_pend_r <= 1'b0;
            end
            if (rx_done) begin
                rx_hold_r <= rx_fmt;
                rx_full_r <= 1'b1;
                par_err_r <= par_en && (((^rx_raw) ^ par_odd) != rx_par_r);
            end else if (rd_rx_hold) begin
                rx_full_r <= 1'b0;
                par_err_r <= 1'b0;
            end
        end
    end

    // Transmitter
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_state_r <= TX_IDLE;
            tx_sh_r    <= 8'h00;
            tx_par_r   <= 1'b0;
            tx_idx_r   <= 3'h0;
            txd_o      <= 1'b1;
            sck_o      <= 1'b1;
        end else begin
            case (tx_state_r)
                TX_IDLE: begin
                    sck_o <= 1'b1;
                    if (tx_go) begin
                        tx_sh_r    <= tx_fmt;
                        tx_par_r   <= tx_par_bit;
                        tx_idx_r   <= 3'h0;
                        tx_state_r <= sync_mode ? TX_DATA : TX_START;
                        txd_o      <= sync_mode ? tx_fmt[0] : 1'b0;
                        sck_o      <= !sync_mode;
                    end
                end
                TX_START: begin
                    if (tx_end) begin
                        tx_state_r <= TX_DATA;
                        txd_o      <= tx_sh_r[0];
                    end
                end
                TX_DATA: begin
                    if (sync_mode && tx_mid) begin
                        sck_o <= 1'b1;
                    end
                    if (tx_end) begin
                        if (tx_idx_r == last_idx) begin
                            tx_state_r <= par_en ? TX_PAR : (sync_mode ? TX_IDLE : TX_STOP);
                            txd_o      <= par_en ? tx_par_r : 1'b1;
                        end else begin
                            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                            tx_idx_r <= tx_idx_r + 3'h1;
                            txd_o    <= tx_sh_r[1];
                            sck_o    <= !sync_mode;
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_end) begin
                        tx_state_r <= TX_STOP;
                        txd_o      <= 1'b1;
                    end
                end
                TX_STOP: begin
                    if (tx_end) begin
                        tx_state_r <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state_r <= TX_IDLE;
                    txd_o      <= 1'b1;
                end
            endcase
        end
    end

    // Receiver; the pin passes two flops before any logic
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_s1_r    <= 1'b1;
            rx_s2_r    <= 1'b1;
            rx_s3_r    <= 1'b1;
            rx_state_r <= RX_IDLE;
            rx_sh_r    <= 8'h00;
            rx_par_r   <= 1'b0;
            rx_idx_r   <= 3'h0;
        end else begin
            rx_s1_r <= rxd_i;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            case (rx_state_r)
                RX_IDLE: begin
                    rx_idx_r <= 3'h0;
                    if (sync_mode && tx_go) begin
                        rx_state_r <= RX_DATA;
                    end else if (rx_clr) begin
                        rx_state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid) begin
                        // A glitch shorter than half a bit is dropped
                        rx_state_r <= rx_s2_r ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]};
                        rx_idx_r <= rx_idx_r + 3'h1;
                        if (rx_idx_r == last_idx) begin
                            rx_state_r <= sync_mode ? RX_IDLE : (par_en ? RX_PAR : RX_STOP);
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_mid) begin
                        rx_par_r   <= rx_s2_r;
                        rx_state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_mid) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // Register reads, data in the following cycle
    always @* begin
        case (addr_i)
            `OFS_CARD_MODE_FORMAT: begin
                rd_mux = `CMF_RESERVED_ONES;
                rd_mux[`CMF_CARD_MODE_SELECT] = card_mode_select_r;
                rd_mux[`CMF_DATA_INVERT]      = data_invert_r;
                rd_mux[`CMF_BIT_ORDER_SELECT] = bit_order_select_r;
            end
            `OFS_BIT_RATE_DIVISOR: rd_mux = bit_rate_divisor_r;
            `OFS_SERIAL_MODE:      rd_mux = serial_mode_r;
            `OFS_TRANSMIT_HOLDING: rd_mux = tx_hold_r;
            `OFS_RECEIVE_HOLDING:  rd_mux = rx_hold_r;
            `OFS_STATUS: begin
                rd_mux = 8'h00;
                rd_mux[`STAT_TX_BUSY]    = tx_pend_r || (tx_state_r != TX_IDLE);
                rd_mux[`STAT_RX_FULL]    = rx_full_r;
                rd_mux[`STAT_PARITY_ERR] = par_err_r;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

endmodule // serial_bit_rate_and_card_format

`default_nettype wire

// *** sim/sbr_checker_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module sbr_checker (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // Register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // Serial line
    input wire logic       rxd_i,
    input wire logic       txd_o,
    input wire logic       sck_o,
    input wire logic       card_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       txd_q_r;
    logic [7:0] run_r;
    // Saturates so a long idle line cannot wrap
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            txd_q_r <= 1'b1;
            run_r   <= 8'h00;
        end else begin
            txd_q_r <= txd_o;
            if (txd_o != txd_q_r)
                run_r <= 8'h00;
            else if (run_r != 8'hFF)
                run_r <= run_r + 8'h01;
        end
    end
    sequence wr_at(a); wr_i && addr_i == a; endsequence
    sequence rd_at(a); rd_i && addr_i == a; endsequence
    property p_div;
        wr_at(3'h1) ##1 rd_at(3'h1) |=> rdata_o == $past(wdata_i, 2);
    endproperty
    property p_cmf;
        wr_at(3'h0) ##1 rd_at(3'h0) |=> rdata_o == (($past(wdata_i, 2) & 8'h0D) | 8'hF2);
    endproperty
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside a read");
    card_ones_a: assert property (rd_at(3'h0) |=> rdata_o[7:4] == 4'hF && rdata_o[1])
        else $error("reserved bits not one");
    card_pin_a: assert property (rd_at(3'h0) |=> rdata_o[0] == card_mode_o)
        else $error("mode pin differs from register");
    card_set_a: assert property (wr_at(3'h0) |=> card_mode_o == $past(wdata_i[0]))
        else $error("mode pin not updated");
    card_wr_rd_a: assert property (p_cmf)
        else $error("mode register readback wrong");
    div_wr_rd_a: assert property (p_div)
        else $error("divisor readback wrong");
    unmapped_a: assert property (rd_i && addr_i[2:1] == 2'b11 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    sck_card_a: assert property (card_mode_o && $past(card_mode_o) |-> sck_o)
        else $error("serial clock moved in card mode");
    txd_run_a: assert property (txd_o != txd_q_r |-> run_r >= 8'h02)
        else $error("line level too short");
endmodule // sbr_checker
bind serial_bit_rate_and_card_format sbr_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rxd_i(rxd_i), .txd_o(txd_o), .sck_o(sck_o), .card_mode_o(card_mode_o));
`default_nettype wire

// *** sim/serial_far_end.sv ***
`timescale 1ns/1ns
`default_nettype none
module serial_far_end (
    // Clock
    input wire logic        clk_i,
    // Line
    input wire logic        txd_i,
    output logic            rxd_o,
    // Frame shape
    input wire logic [15:0] bit_len_i,
    input wire logic        seven_i,
    input wire logic        par_en_i,
    // Frame to send, first bit in bit 0
    input wire logic [9:0]  send_bits_i,
    input wire logic        send_go_i,
    // Captured frame
    output logic [7:0]      got_data_o,
    output logic            got_par_o,
    output logic            got_stop_o,
    output logic [7:0]      got_cnt_o
);
    // Samples on falling clock edges
    initial begin
        got_cnt_o = 8'h00;
        forever begin
            @(negedge txd_i);
            repeat (bit_len_i / 2) @(negedge clk_i);
            got_data_o = 8'h00;
            for (int i = 0; i < (seven_i ? 7 : 8); i++) begin
                repeat (bit_len_i) @(negedge clk_i);
                got_data_o[i] = txd_i;
            end
            if (par_en_i) begin
                repeat (bit_len_i) @(negedge clk_i);
                got_par_o = txd_i;
            end
            repeat (bit_len_i) @(negedge clk_i);
            got_stop_o = txd_i;
            got_cnt_o = got_cnt_o + 8'h01;
        end
    end
    // Line idles at mark
    initial begin
        rxd_o = 1'b1;
        forever begin
            @(posedge send_go_i);
            for (int i = 0; i < 10; i++) begin
                rxd_o <= send_bits_i[i];
                repeat (bit_len_i) @(posedge clk_i);
            end
            rxd_o <= 1'b1;
        end
    end
endmodule // serial_far_end
`default_nettype wire

// *** sim/serial_bit_rate_and_card_format_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module serial_bit_rate_and_card_format_tb_top;
    typedef struct packed {logic [7:0] cmf, serial_mode_register, data, exp; logic par;} fmt_t;
    typedef struct packed {logic [7:0] cmf, serial_mode_register, div; logic [15:0] t;} rate_t;
    logic        clk_i, rst_n_i, wr_i, rd_i, rxd_i, txd_o, sck_o, card_mode_o;
    logic [2:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o, got_data, got_cnt, c;
    logic        seven, par_en, send_go, got_par, got_stop;
    logic [15:0] rd_val, t, u;
    int          num_errors, samples_checked;
    fmt_t fmt [6] = '{'{8'h00, 8'h00, 8'hA3, 8'hA3, 1'b0}, '{8'h08, 8'h00, 8'hA3, 8'hC5, 1'b0},
        '{8'h04, 8'h40, 8'hA3, 8'h5C, 1'b0}, '{8'h0C, 8'hC0, 8'hA3, 8'h3A, 1'b1},
        '{8'h08, 8'h20, 8'h35, 8'h35, 1'b0}, '{8'h04, 8'h60, 8'h35, 8'h4A, 1'b0}};
    rate_t rate [9] = '{'{8'h00, 8'h00, 8'h00, 16'h0020}, '{8'h00, 8'h01, 8'h02, 16'h0180},
        '{8'h00, 8'h03, 8'h00, 16'h0800}, '{8'h01, 8'h00, 8'h00, 16'h0040},
        '{8'h01, 8'h04, 8'h01, 16'h0100}, '{8'h01, 8'h08, 8'h00, 16'h02E8},
        '{8'h01, 8'h0C, 8'h00, 16'h0200}, '{8'h00, 8'h10, 8'h01, 16'h0008},
        '{8'h00, 8'h12, 8'h00, 16'h0040}};
    serial_bit_rate_and_card_format dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i),
        .txd_o(txd_o), .sck_o(sck_o), .card_mode_o(card_mode_o));
    serial_far_end far (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .bit_len_i(16'h0020),
        .seven_i(seven), .par_en_i(par_en), .send_bits_i(10'h25A), .send_go_i(send_go),
        .got_data_o(got_data), .got_par_o(got_par), .got_stop_o(got_stop), .got_cnt_o(got_cnt));
    task automatic report_and_stop;
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        num_errors++;
        $display("Error at %0t: wait ran out", $time);
        report_and_stop;
    endtask
    // Bus tasks start and end just after a rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        @(posedge clk_i);
        #1;
        rd_val = {8'h00, rdata_o};
    endtask
    task automatic idle;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic poll(input int b, input logic v);
        int k;
        k = 0;
        do begin
            rd(3'h5);
            k++;
        end while (rd_val[b] !== v && k < 30000);
        idle;
        if (k >= 30000) hang;
    endtask
    task automatic wait_lvl(input logic sel, input logic lvl, output logic [15:0] n);
        n = 16'h0000;
        while ((sel ? sck_o : txd_o) !== lvl && n < 16'h7530) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 16'h7530) hang;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {rst_n_i, wr_i, rd_i, send_go, seven, par_en} = 6'h00;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        num_errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_i);
        #1;
        rst_n_i <= 1'b1;
        rd(3'h0); check(rd_val, 16'h00F2);
        rd(3'h1); check(rd_val, 16'h00FF);
        rd(3'h6); check(rd_val, 16'h0000);
        check({15'h0000, card_mode_o}, 16'h0000);
        foreach (fmt[i]) begin
            wr(3'h0, ~fmt[i].data); rd(3'h0); check(rd_val, {8'h00, ~fmt[i].data & 8'h0D | 8'hF2});
            check({15'h0000, card_mode_o}, {15'h0000, ~fmt[i].data[0]});
            wr(3'h1, fmt[i].exp); rd(3'h1); check(rd_val, {8'h00, fmt[i].exp});
        end
        wr(3'h7, 8'h55); rd(3'h1); check(rd_val, 16'h004A);
        // Data format, fastest async
        wr(3'h1, 8'h00); repeat (256) idle;
        foreach (fmt[i]) begin
            wr(3'h2, fmt[i].serial_mode_register); wr(3'h0, fmt[i].cmf); wr(3'h1, 8'h00);
            seven = fmt[i].serial_mode_register[5];
            par_en = fmt[i].serial_mode_register[6];
            c = got_cnt;
            wr(3'h3, fmt[i].data); idle;
            wait_lvl(1'b0, 1'b0, t);
            for (int k = 0; k < 600 && got_cnt === c; k++) @(posedge clk_i);
            if (got_cnt === c) hang;
            check({8'h00, got_data}, {8'h00, fmt[i].exp});
            if (fmt[i].serial_mode_register[6]) check({15'h0000, got_par}, {15'h0000, fmt[i].par});
            check({15'h0000, got_stop}, 16'h0001);
            poll(0, 1'b0);
        end
        // Bit period per mode, prescale, divisor, base code
        foreach (rate[i]) begin
            wr(3'h2, rate[i].serial_mode_register); wr(3'h0, rate[i].cmf); wr(3'h1, rate[i].div);
            wr(3'h3, 8'h01); idle;
            if (rate[i].serial_mode_register[4] && !rate[i].cmf[0]) begin
                wait_lvl(1'b1, 1'b0, t); wait_lvl(1'b1, 1'b1, t); wait_lvl(1'b1, 1'b0, t);
                wait_lvl(1'b1, 1'b1, t); wait_lvl(1'b1, 1'b0, u);
                t = t + u;
            end else begin
                wait_lvl(1'b0, 1'b0, t); wait_lvl(1'b0, 1'b1, t); wait_lvl(1'b0, 1'b0, t);
            end
            check(t, rate[i].t);
            poll(0, 1'b0);
        end
        // Receive MSB first with inversion
        wr(3'h0, 8'h0C); wr(3'h2, 8'h00); wr(3'h1, 8'h00); rd(3'h4); idle;
        send_go <= 1'b1;
        idle;
        send_go <= 1'b0;
        poll(1, 1'b1);
        rd(3'h4); check(rd_val, 16'h004B);
        // Mid-run reset restores defaults
        wr(3'h1, 8'h12); wr(3'h0, 8'h0D); idle;
        rst_n_i <= 1'b0;
        repeat (2) idle;
        rst_n_i <= 1'b1;
        rd(3'h0); check(rd_val, 16'h00F2);
        rd(3'h1); check(rd_val, 16'h00FF);
        idle;
        check({15'h0000, card_mode_o}, 16'h0000);
        report_and_stop;
    end
endmodule // serial_bit_rate_and_card_format_tb_top
`default_nettype wire
